/* File: hw/mic_pkg.sv */
// Shared constants for the monitor interrupt control block.
package mic_pkg;

    // Register byte addresses on the internal register port
    localparam logic [7:0] ADDR_MAIN_CFG = 8'h40; // Main configuration
    localparam logic [7:0] ADDR_FLAGS_ONE = 8'h41; // Event flags, first
    localparam logic [7:0] ADDR_FLAGS_TWO = 8'h42; // Event flags, second
    localparam logic [7:0] ADDR_MASK_ONE = 8'h43; // Event mask, first
    localparam logic [7:0] ADDR_MASK_TWO = 8'h44; // Event mask, second
    localparam logic [7:0] ADDR_AUX_CFG = 8'h4a; // Second configuration
    localparam logic [7:0] ADDR_MIRROR_ONE = 8'h4c; // Mirror of flags one
    localparam logic [7:0] ADDR_MIRROR_TWO = 8'h4d; // Mirror of flags two

    // Main configuration bit positions
    localparam int unsigned CFG_START = 0; // Monitoring run/standby
    localparam int unsigned CFG_INT_EN = 1; // General interrupt enable
    localparam int unsigned CFG_OT_EN = 2; // Overtemperature enable
    localparam int unsigned CFG_INT_CLR = 3; // General interrupt release
    localparam int unsigned CFG_RST_PULSE = 4; // Reset pulse request
    localparam int unsigned CFG_OT_CLR = 6; // overtemp_line_release
    localparam int unsigned CFG_REINIT = 7; // Reload defaults

    // Second configuration bit positions
    localparam int unsigned AUX_OVERTEMP_LINE_N_MASK = 0; // Thermal events off INT

    // Second flag register bit positions
    localparam int unsigned FL2_TWELVE = 0; // rail_twelve limit
    localparam int unsigned FL2_CORE_B = 1; // core_rail_b limit
    localparam int unsigned FL2_ENCL = 4; // enclosure_open seen high
    localparam int unsigned FL2_OT_PIN = 5; // Overtemp pin pulled low
    localparam int unsigned FL2_DIODE_A = 6; // diode_a_fault
    localparam int unsigned FL2_DIODE_B = 7; // diode_b_fault

    // Reset values
    localparam logic [7:0] MAIN_CFG_RST = 8'h08;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] AUX_CFG_RST = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00; // Unmapped address answer

    // Storable bits of main configuration; re-init bit is never held
    localparam logic [7:0] MAIN_CFG_HOLD = 8'h7f;
    // Implemented bits of the second flag register
    localparam logic [7:0] FLAGS_TWO_USED = 8'hf3;
    // Limit-event positions of the second flag register
    localparam logic [1:0] FLAGS_TWO_LIMITS = 2'h3;
    // Thermal event positions, gated off INT by the thermal mask
    localparam logic [7:0] OVERTEMP_LINE_N_GROUP_ONE = 8'h30;
    localparam logic [7:0] OVERTEMP_LINE_N_GROUP_TWO = 8'h20;

    // Timing
    localparam longint unsigned CLK_HZ = 64'd20_000_000; // core_clk rate
    localparam longint unsigned RESET_PULSE_MS = 64'd20; // Least pulse
    localparam longint unsigned MS_PER_S = 64'd1000;
    // Least time rounds up to whole cycles
    localparam int unsigned RESET_PULSE_CYCLES =
        int'((RESET_PULSE_MS * CLK_HZ + MS_PER_S - 64'd1) / MS_PER_S);

endpackage

/* File: hw/mic_reset_pulse.sv */
// Timed active-low reset pulse generator for the reset output pin.
`timescale 1ns/1ps
module mic_reset_pulse #(
    parameter int unsigned PULSE_CYCLES = mic_pkg::RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Control
    input wire logic trigger,
    // Status and pin
    output logic busy,
    output logic donePulse,
    output logic resetLineN
);

    localparam int unsigned CW = $clog2(PULSE_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);
    localparam logic [CW-1:0] ZERO = '0;
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] count_r; // Cycles spent low so far
    logic [CW-1:0] count_nxt;
    logic active_r; // Pin held low
    logic active_nxt;
    logic done_r; // Pin just returned high
    logic done_nxt;

    // Next-state: start on trigger, hold low a full count, then release
    always_comb begin
        count_nxt = count_r;
        active_nxt = active_r;
        done_nxt = 1'b0;
        if (!active_r) begin
            // A trigger while busy is ignored; the pulse is never cut short
            if (trigger) begin
                active_nxt = 1'b1;
                count_nxt = ZERO;
            end
        end else if (count_r == LAST) begin
            active_nxt = 1'b0;
            done_nxt = 1'b1;
        end else begin
            count_nxt = count_r + ONE;
        end
    end

    // State registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= ZERO;
            active_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            active_r <= active_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = active_r;
    assign donePulse = done_r;
    // Pin low while active, straight from a flip-flop
    assign resetLineN = ~active_r;

endmodule

/* File: hw/mic_control.sv */
// Control, event flag and interrupt logic of the hardware monitor.
`timescale 1ns/1ps
module mic_control #(
    parameter int unsigned RESET_PULSE_CYCLES = mic_pkg::RESET_PULSE_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port from the serial interface front end
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    // Limit comparator results, one-cycle or level
    input wire logic [7:0] limitHitOne,
    input wire logic [1:0] limitHitTwo,
    // Fault and sensor inputs
    input wire logic enclosureOpen,
    input wire logic diodeAFault,
    input wire logic diodeBFault,
    input wire logic thermalLimitHit,
    // Open-drain overtemperature pin
    input wire logic overtempLineIn,
    output logic overtempLineOut,
    output logic overtempLineOe,
    // General interrupt pin, active low
    output logic intLineN,
    // Reset output pin, active low
    output logic resetLineN,
    // Monitoring control toward scanner and comparators
    output logic scanEnable,
    output logic compareEnable,
    output logic reinitPulse
);

    // Address match helper shared by write and read decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = (a == b);
    endfunction

    // Configuration state
    logic [7:0] mainCfg_r; // Main configuration, bit 7 never held
    logic [7:0] mainCfg_nxt;
    logic [7:0] auxCfg_r; // Second configuration
    logic [7:0] auxCfg_nxt;
    logic [7:0] maskOne_r; // Event mask one
    logic [7:0] maskOne_nxt;
    logic [7:0] maskTwo_r; // Event mask two
    logic [7:0] maskTwo_nxt;
    logic reinit_r; // One-cycle reload strobe to neighbours
    logic reinit_nxt;

    // Event flag state
    logic [7:0] flagsOne_r; // Sticky flags one
    logic [7:0] flagsOne_nxt;
    logic [7:0] flagsTwo_r; // Sticky flags two
    logic [7:0] flagsTwo_nxt;

    // Pin and read state
    logic intLineN_r; // General interrupt pin level
    logic intLineN_nxt;
    logic otDrive_r; // Overtemp pin pulled low by us
    logic otDrive_nxt;
    logic [7:0] rdData_r; // Read answer
    logic [7:0] rdData_nxt;
    logic rdValid_r;
    logic rdValid_nxt;

    // Decoded strobes and derived levels
    logic wrMain;
    logic wrReinit;
    logic pulseStart;
    logic pulseBusy;
    logic pulseDone;
    logic monitorRun;
    logic rdClrOne;
    logic rdClrTwo;
    logic [7:0] setOne;
    logic [7:0] setTwo;
    logic [7:0] intSrcOne;
    logic [7:0] intSrcTwo;

    // Monitoring runs only with start set and INT release clear
    assign monitorRun = mainCfg_r[mic_pkg::CFG_START] &
        ~mainCfg_r[mic_pkg::CFG_INT_CLR];
    // Scanning and comparison begin together
    assign scanEnable = monitorRun;
    assign compareEnable = monitorRun;

    // Write decode; writes to the flag addresses fall through unused
    assign wrMain = regWrEn && hit(regAddr, mic_pkg::ADDR_MAIN_CFG);
    assign wrReinit = wrMain && regWrData[mic_pkg::CFG_REINIT];
    // Pulse request only starts when the generator is idle
    assign pulseStart = wrMain && !wrReinit &&
        regWrData[mic_pkg::CFG_RST_PULSE] && !pulseBusy;

    // Flag clearing on a read of the primary address; mirrors do not clear
    assign rdClrOne = regRdEn && hit(regAddr, mic_pkg::ADDR_FLAGS_ONE);
    assign rdClrTwo = regRdEn && hit(regAddr, mic_pkg::ADDR_FLAGS_TWO);

    // Configuration group next values
    always_comb begin
        mainCfg_nxt = mainCfg_r;
        auxCfg_nxt = auxCfg_r;
        maskOne_nxt = maskOne_r;
        maskTwo_nxt = maskTwo_r;
        reinit_nxt = 1'b0;
        if (wrReinit) begin
            // Reload wins over every other bit of the same write
            mainCfg_nxt = mic_pkg::MAIN_CFG_RST;
            auxCfg_nxt = mic_pkg::AUX_CFG_RST;
            maskOne_nxt = mic_pkg::MASK_RST;
            maskTwo_nxt = mic_pkg::MASK_RST;
            reinit_nxt = 1'b1;
        end else begin
            if (wrMain) begin
                // Bit 7 is dropped, so it always reads zero
                mainCfg_nxt = regWrData & mic_pkg::MAIN_CFG_HOLD;
                // A running pulse keeps its bit set whatever is written
                mainCfg_nxt[mic_pkg::CFG_RST_PULSE] =
                    pulseBusy | regWrData[mic_pkg::CFG_RST_PULSE];
            end else if (regWrEn && hit(regAddr, mic_pkg::ADDR_MASK_ONE)) begin
                maskOne_nxt = regWrData;
            end else if (regWrEn && hit(regAddr, mic_pkg::ADDR_MASK_TWO)) begin
                maskTwo_nxt = regWrData;
            end else if (regWrEn && hit(regAddr, mic_pkg::ADDR_AUX_CFG)) begin
                auxCfg_nxt = regWrData;
            end
            // Pulse end clears the request bit by itself, unless a new
            // pulse starts in that same cycle: the fresh request wins
            if (pulseDone && !pulseStart) begin
                mainCfg_nxt[mic_pkg::CFG_RST_PULSE] = 1'b0;
            end
        end
    end

    // Configuration group registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mainCfg_r <= mic_pkg::MAIN_CFG_RST;
            auxCfg_r <= mic_pkg::AUX_CFG_RST;
            maskOne_r <= mic_pkg::MASK_RST;
            maskTwo_r <= mic_pkg::MASK_RST;
            reinit_r <= 1'b0;
        end else begin
            mainCfg_r <= mainCfg_nxt;
            auxCfg_r <= auxCfg_nxt;
            maskOne_r <= maskOne_nxt;
            maskTwo_r <= maskTwo_nxt;
            reinit_r <= reinit_nxt;
        end
    end

    assign reinitPulse = reinit_r;

    // Event sources; comparator-fed ones only count while monitoring runs
    always_comb begin
        setOne = limitHitOne & {8{monitorRun}};
        setTwo = mic_pkg::FLAGS_RST;
        setTwo[mic_pkg::FL2_TWELVE] =
            limitHitTwo[mic_pkg::FL2_TWELVE] & monitorRun;
        setTwo[mic_pkg::FL2_CORE_B] =
            limitHitTwo[mic_pkg::FL2_CORE_B] & monitorRun;
        // Intrusion is watched even in standby
        setTwo[mic_pkg::FL2_ENCL] = enclosureOpen;
        // Only an outside pull counts, never our own drive
        setTwo[mic_pkg::FL2_OT_PIN] = !overtempLineIn && !otDrive_r;
        setTwo[mic_pkg::FL2_DIODE_A] = diodeAFault & monitorRun;
        setTwo[mic_pkg::FL2_DIODE_B] = diodeBFault & monitorRun;
    end

    // Flag group next values; a set in the clearing cycle survives
    always_comb begin
        flagsOne_nxt = flagsOne_r;
        flagsTwo_nxt = flagsTwo_r;
        if (wrReinit) begin
            flagsOne_nxt = mic_pkg::FLAGS_RST;
            flagsTwo_nxt = mic_pkg::FLAGS_RST;
        end
        if (rdClrOne) begin
            flagsOne_nxt = mic_pkg::FLAGS_RST;
        end
        if (rdClrTwo) begin
            flagsTwo_nxt = mic_pkg::FLAGS_RST;
        end
        flagsOne_nxt = flagsOne_nxt | setOne;
        // Reserved positions can never be set
        flagsTwo_nxt = (flagsTwo_nxt | setTwo) &
            mic_pkg::FLAGS_TWO_USED;
    end

    // Flag group registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flagsOne_r <= mic_pkg::FLAGS_RST;
            flagsTwo_r <= mic_pkg::FLAGS_RST;
        end else begin
            flagsOne_r <= flagsOne_nxt;
            flagsTwo_r <= flagsTwo_nxt;
        end
    end

    // Interrupt sources after masks and the thermal mask
    always_comb begin
        intSrcOne = flagsOne_r & ~maskOne_r;
        intSrcTwo = flagsTwo_r & ~maskTwo_r;
        if (auxCfg_r[mic_pkg::AUX_OVERTEMP_LINE_N_MASK]) begin
            intSrcOne = intSrcOne & ~mic_pkg::OVERTEMP_LINE_N_GROUP_ONE;
            intSrcTwo = intSrcTwo & ~mic_pkg::OVERTEMP_LINE_N_GROUP_TWO;
        end
    end

    // Pin group next values
    always_comb begin
        // Start bit is not in this term, so standby keeps the pin low
        intLineN_nxt = !(mainCfg_r[mic_pkg::CFG_INT_EN] &&
            !mainCfg_r[mic_pkg::CFG_INT_CLR] &&
            (|{intSrcOne, intSrcTwo}));
        // Overtemp drive ignores the thermal mask on purpose
        otDrive_nxt = mainCfg_r[mic_pkg::CFG_OT_EN] &&
            !mainCfg_r[mic_pkg::CFG_OT_CLR] &&
            thermalLimitHit;
    end

    // Pin group registers, so the pins never glitch
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            intLineN_r <= 1'b1;
            otDrive_r <= 1'b0;
        end else begin
            intLineN_r <= intLineN_nxt;
            otDrive_r <= otDrive_nxt;
        end
    end

    assign intLineN = intLineN_r;
    // Open drain: low level whenever enabled, released otherwise
    assign overtempLineOut = 1'b0;
    assign overtempLineOe = otDrive_r;

    // Read group next values; unmapped addresses answer zero
    always_comb begin
        rdValid_nxt = regRdEn;
        rdData_nxt = rdData_r;
        if (regRdEn) begin
            if (hit(regAddr, mic_pkg::ADDR_MAIN_CFG)) begin
                rdData_nxt = mainCfg_r;
            end else if (hit(regAddr, mic_pkg::ADDR_FLAGS_ONE) ||
                hit(regAddr, mic_pkg::ADDR_MIRROR_ONE)) begin
                rdData_nxt = flagsOne_r;
            end else if (hit(regAddr, mic_pkg::ADDR_FLAGS_TWO) ||
                hit(regAddr, mic_pkg::ADDR_MIRROR_TWO)) begin
                rdData_nxt = flagsTwo_r;
            end else if (hit(regAddr, mic_pkg::ADDR_MASK_ONE)) begin
                rdData_nxt = maskOne_r;
            end else if (hit(regAddr, mic_pkg::ADDR_MASK_TWO)) begin
                rdData_nxt = maskTwo_r;
            end else if (hit(regAddr, mic_pkg::ADDR_AUX_CFG)) begin
                rdData_nxt = auxCfg_r;
            end else begin
                rdData_nxt = mic_pkg::READ_NONE;
            end
        end
    end

    // Read group registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_r <= mic_pkg::READ_NONE;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    assign regRdData = rdData_r;
    assign regRdValid = rdValid_r;

    // Reset pulse timer; long count is a parameter so tests can shorten it
    mic_reset_pulse #(
        .PULSE_CYCLES(RESET_PULSE_CYCLES)
    ) u_reset_pulse (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .trigger(pulseStart),
        .busy(pulseBusy),
        .donePulse(pulseDone),
        .resetLineN(resetLineN)
    );

endmodule

/* File: bench/mic_control_sva.sv */
// Concurrent checks on the ports of the monitor interrupt control block.
`timescale 1ns/1ps
module mic_control_sva #(
    parameter int unsigned RESET_PULSE_CYCLES = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    // Pins and control outputs
    input wire logic thermalLimitHit,
    input wire logic overtempLineOut,
    input wire logic overtempLineOe,
    input wire logic intLineN,
    input wire logic resetLineN,
    input wire logic scanEnable,
    input wire logic compareEnable,
    input wire logic reinitPulse
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Length of the current low stretch on the reset output
    int unsigned lowCnt_r;
    int unsigned lowCnt_nxt;

    // Counter restarts whenever the pin is high
    always_comb begin
        lowCnt_nxt = resetLineN ? 0 : lowCnt_r + 1;
    end

    // Register the counter
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lowCnt_r <= 0;
        end else begin
            lowCnt_r <= lowCnt_nxt;
        end
    end

    a_pulse_exact_length: assert property (
        $rose(resetLineN) |-> lowCnt_r == RESET_PULSE_CYCLES)
        else $error("reset pulse length wrong");
    a_pulse_never_long: assert property (
        lowCnt_r <= RESET_PULSE_CYCLES)
        else $error("reset pulse too long");
    a_pulse_has_cause: assert property (
        $fell(resetLineN) |->
        $past(regWrEn && regAddr == 8'h40 && regWrData[4]))
        else $error("reset pulse without request");
    a_reinit_follows_write: assert property (
        regWrEn && regAddr == 8'h40 && regWrData[7] |=> reinitPulse)
        else $error("no reinit pulse");
    a_reinit_has_cause: assert property (
        reinitPulse |->
        $past(regWrEn && regAddr == 8'h40 && regWrData[7]))
        else $error("stray reinit pulse");
    a_reinit_reads_zero: assert property (
        regRdEn && regAddr == 8'h40 |=> !regRdData[7])
        else $error("reinit bit reads one");
    a_reserved_read_zero: assert property (
        regRdEn && regAddr inside {8'h42, 8'h4d} |=>
        regRdData[3:2] == 2'h0)
        else $error("reserved flags set");
    a_scan_compare_pair: assert property (
        scanEnable == compareEnable)
        else $error("scan and compare differ");
    a_otline_drives_low: assert property (
        overtempLineOut == 1'b0)
        else $error("open drain data high");
    a_ot_rise_cause: assert property (
        $rose(overtempLineOe) |-> $past(thermalLimitHit))
        else $error("overtemp pin without cause");

    // Main scenarios
    c_pulse_done: cover property ($rose(resetLineN));
    c_int_asserted: cover property ($fell(intLineN));
    c_reinit_seen: cover property (reinitPulse);
endmodule

/* File: bench/mic_host.sv */
// Host-side model that drives the internal register port.
`timescale 1ns/1ps
module mic_host (
    // Clock
    input wire logic core_clk,
    // Register port toward the block
    output logic [7:0] regAddr = 8'h00,
    output logic [7:0] regWrData = 8'h00,
    output logic regWrEn = 1'b0,
    output logic regRdEn = 1'b0
);
    // One write; strobe stands one cycle, then bus shows inverted junk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    // One read; inverted address afterwards so stale values cannot pass
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
    endtask
endmodule

/* File: bench/monitor_interrupt_control_bench.sv */
// Self-checking bench for the monitor interrupt control block.
`timescale 1ns/1ps
module monitor_interrupt_control_bench;
    localparam int unsigned PULSE = 8; // Short pulse keeps the run brief
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] regAddr, regWrData, regRdData;
    logic regWrEn, regRdEn, regRdValid, overtempLineOut, overtempLineOe;
    logic intLineN, resetLineN, scanEnable, compareEnable, reinitPulse;
    // Event inputs: 7:0 flags one, 9:8 rails, 11 thermal, 12 enclosure,
    // 13 outside pull on overtemp pin, 14/15 diode faults
    logic [15:0] evt = 16'h0000;
    wire overtempLineIn = ~(overtempLineOe | evt[13]); // Wired open drain
    logic [7:0] expQ[$]; // Expected read answers, oldest first
    logic [7:0] m, e, fAddr;
    int err_total = 0;
    int n_tests = 0;
    int cyc = 0;
    int n;
    int evList[14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 12, 13, 14, 15};
    logic [7:0] dAddr[9] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h4a,
                             8'h4c, 8'h4d, 8'h45};
    logic [7:0] dVal[9] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                            8'h00, 8'h00, 8'h00};

    always #25 core_clk = ~core_clk;

    mic_control #(.RESET_PULSE_CYCLES(PULSE)) u_mic_control (
        .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .regRdValid(regRdValid),
        .limitHitOne(evt[7:0]), .limitHitTwo(evt[9:8]),
        .enclosureOpen(evt[12]), .diodeAFault(evt[14]),
        .diodeBFault(evt[15]), .thermalLimitHit(evt[11]),
        .overtempLineIn(overtempLineIn), .overtempLineOut(overtempLineOut),
        .overtempLineOe(overtempLineOe), .intLineN(intLineN),
        .resetLineN(resetLineN), .scanEnable(scanEnable),
        .compareEnable(compareEnable), .reinitPulse(reinitPulse));

    mic_host u_mic_host (.core_clk(core_clk), .regAddr(regAddr),
        .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn));

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_mic_host.wr(a, d);
    endtask

    // Note the answer first, then issue the read
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        expQ.push_back(x);
        u_mic_host.rd(a);
    endtask

    // One-cycle event on input k
    task automatic fire(input int k);
        @(posedge core_clk);
        evt <= 16'h0001 << k;
        @(posedge core_clk);
        evt <= 16'h0000;
    endtask

    // Registered pins need two edges after the cause
    task automatic settle();
        repeat (3) @(negedge core_clk);
    endtask

    // Read answers appear one cycle after the strobe
    always @(negedge core_clk) begin
        if (regRdValid === 1'b1) begin
            if (expQ.size() > 0) chk(regRdData, expQ.pop_front());
            else chk(regRdData, 8'hxx);
        end
    end

    // Cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        void'($urandom(32'hdd3b));
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        @(negedge core_clk);
        chk(intLineN, 1'b1);
        chk(scanEnable, 1'b0);
        for (int i = 0; i < 9; i++) rd(dAddr[i], dVal[i]);
        fire(0);
        rd(8'h41, 8'h00);
        $display("test 1 finished");
        // Writes to flag places are ignored; masks and aux are plain storage
        m = $urandom;
        wr(8'h41, m);
        wr(8'h42, ~m);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        wr(8'h43, m);
        rd(8'h43, m);
        wr(8'h44, ~m);
        rd(8'h44, ~m);
        wr(8'h4a, m & 8'hfe);
        rd(8'h4a, m & 8'hfe);
        wr(8'h43, 8'h00);
        wr(8'h44, 8'h00);
        wr(8'h4a, 8'h00);
        $display("test 2 finished");
        // Start with INT enabled; every event except thermal (11) sets its own flag
        wr(8'h40, 8'h03);
        settle();
        chk(scanEnable, 1'b1);
        foreach (evList[i]) begin
            fire(evList[i]);
            settle();
            chk(intLineN, 1'b0);
            e = 8'h01 << (evList[i] % 8);
            fAddr = evList[i] < 8 ? 8'h41 : 8'h42;
            rd(fAddr + 8'h0b, e);
            rd(fAddr, e);
            rd(fAddr, 8'h00);
        end
        $display("test 3 finished");
        // Masked and thermal-masked events keep INT high but still flag
        wr(8'h43, 8'h01);
        fire(0);
        settle();
        chk(intLineN, 1'b1);
        rd(8'h41, 8'h01);
        wr(8'h43, 8'h00);
        wr(8'h4a, 8'h01);
        fire(4);
        settle();
        chk(intLineN, 1'b1);
        rd(8'h41, 8'h10);
        wr(8'h4a, 8'h00);
        $display("test 4 finished");
        // Release bit hides INT and halts; clearing start does not release
        fire(1);
        settle();
        chk(intLineN, 1'b0);
        wr(8'h40, 8'h0b);
        settle();
        chk(intLineN, 1'b1);
        chk(scanEnable, 1'b0);
        rd(8'h4c, 8'h02);
        wr(8'h40, 8'h02);
        settle();
        chk(intLineN, 1'b0);
        chk(scanEnable, 1'b0);
        rd(8'h41, 8'h02);
        settle();
        chk(intLineN, 1'b1);
        $display("test 5 finished");
        // Overtemp output enable and release
        wr(8'h40, 8'h05);
        @(posedge core_clk);
        evt <= 16'h0800;
        settle();
        chk(overtempLineOe, 1'b1);
        wr(8'h40, 8'h45);
        settle();
        chk(overtempLineOe, 1'b0);
        @(posedge core_clk);
        evt <= 16'h0000;
        $display("test 6 finished");
        // Reset pulse length and self-clear
        wr(8'h40, 8'h10);
        // Pin is low from the write edge on, so count from the next negedge
        @(negedge core_clk);
        n = 0;
        while (resetLineN === 1'b0 && n < 100) begin
            n++;
            @(negedge core_clk);
        end
        chk(8'(n), 8'(PULSE));
        rd(8'h40, 8'h00);
        $display("test 7 finished");
        // Re-initialisation restores defaults and reads back zero
        wr(8'h43, 8'hff);
        wr(8'h40, 8'h83);
        rd(8'h40, 8'h08);
        rd(8'h43, 8'h00);
        repeat (4) @(negedge core_clk);
        chk(8'(expQ.size()), 8'h00);
        $display("test 8 finished");
        end_of_test();
    end
endmodule

bind mic_control mic_control_sva #(
    .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) u_mic_control_sva (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .regRdValid(regRdValid),
    .thermalLimitHit(thermalLimitHit), .overtempLineOut(overtempLineOut),
    .overtempLineOe(overtempLineOe), .intLineN(intLineN),
    .resetLineN(resetLineN), .scanEnable(scanEnable),
    .compareEnable(compareEnable), .reinitPulse(reinitPulse));
